// [rtl/lpms_sequencer.v]
// low power mode sequencer: moves the chip between run, sleep, three
// deep-sleep grades and standby, gates clocks, oscillators and domain power,
// picks the wake sources per mode and latches the boot target.
// assumes one 50 MHz sys_clk, the cpu on the same clock, and wake sources,
// boot pins and the reset pin arriving asynchronously.
//
// Behaviour
// - sample boot pins at startup; pick flash, loader or sram; flash default
// - sleep stops only the core clock; any interrupt or event wakes
// - deep-sleep grades stop 1.1V clocks, rc oscillators, crystal, plls
// - basic deep-sleep keeps all sram and registers powered
// - every deep-sleep grade wakes on any event controller source
// - leaving any deep-sleep grade forces system clock to the 8 MHz rc
// - deep-sleep 1 removes power from switchable domain b
// - wake from deep-sleep 1 waits extra to re-power domain b
// - deep-sleep 2 removes both switchable domains, keeps only low sram
// - wake from deep-sleep 2 waits extra to re-power both domains
// - standby powers off 1.1V domain, regulator and all oscillators
// - standby exits only on reset pin, rtc alarm, watchdog, wakeup pin rise
// - independent watchdog keeps running in every low power mode
`timescale 1ns/100ps
`default_nettype none
`include "lpms_defs.vh"

module lpms_sequencer #(
   parameter CNT_W = 8,
   parameter DEEP1_REPOWER = `LPMS_DEEP1_REPOWER,
   parameter DEEP2_REPOWER = `LPMS_DEEP2_REPOWER
) (
   input wire sys_clk,
   input wire reset,
   // register port
   input wire [`LPMS_ADDR_W-1:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [31:0] reg_rdata,
   // cpu side
   input wire sleep_req,
   input wire [2:0] sleep_mode,
   input wire any_irq,
   // asynchronous pins and wake sources
   input wire boot0_pin,
   input wire boot1_pin,
   input wire [15:0] external_event_controller_lines,
   input wire rtc_alarm,
   input wire low_voltage_detector,
   input wire usb_wake,
   input wire enet_wake,
   input wire i2c_wake,
   input wire usart_wake,
   input wire external_reset_pin_n,
   input wire independent_watchdog_reset,
   input wire wakeup_pin,
   // power and clock controls
   output reg core_clk_en,
   output reg domain_clk_en,
   output reg internal_rc_8mhz_en,
   output reg internal_rc_48mhz_en,
   output reg external_fast_crystal_osc_en,
   output reg pll_en,
   output reg switchable_core_domain_a_pwr,
   output reg switchable_core_domain_b_pwr,
   output reg core_regulator_en,
   output reg sram_upper_retain,
   output wire independent_watchdog_run,
   output reg [1:0] sysclk_src,
   output reg [1:0] boot_target,
   output reg boot_valid,
   output reg chip_restart
);

   // ****************************************************************
   // states
   // ****************************************************************
   localparam ST_BOOT = 3'h0;
   localparam ST_RUN = 3'h1;
   localparam ST_SLEEP = 3'h2;
   localparam ST_DEEP = 3'h3;
   localparam ST_STANDBY = 3'h4;
   localparam ST_POWERUP = 3'h5;
   localparam SYNC_W = 27;

   reg [2:0] state;
   reg [2:0] next_state;
   reg [2:0] mode;
   reg [2:0] next_mode;
   reg [CNT_W-1:0] repower_cnt;
   reg [CNT_W-1:0] next_repower_cnt;
   reg [1:0] boot_cnt;
   reg [SYNC_W-1:0] sync1;
   reg [SYNC_W-1:0] sync2;
   reg wakeup_pin_prev;
   reg [`LPMS_WC_W-1:0] wake_cause;
   reg [`LPMS_WC_W-1:0] wake_hit;
   reg deep_exit;
   reg restart_now;
   wire [9:0] ctl;

   // control vector of a state:
   // {core, dom clk, rc8, rc48, xtal, pll, dom a, dom b, regulator, sram hi}
   function [9:0] ctl_of;
      input [2:0] st;
      input [2:0] md;
      begin
         case (st)
            ST_SLEEP: ctl_of = 10'h1ff; // only the core clock stops
            ST_DEEP: begin
               // clocks and oscillators off; power by grade
               ctl_of = {6'h00,
                         md != `LPMS_MODE_DEEP2, // domain a
                         md == `LPMS_MODE_DEEP, // domain b
                         1'b1,
                         md != `LPMS_MODE_DEEP2}; // low sram only
            end
            ST_STANDBY: ctl_of = 10'h000; // whole 1.1V area off
            // re-powering: domains up, rc8 clocking, core still gated
            ST_POWERUP: ctl_of = 10'h18f;
            default: ctl_of = 10'h3ff;
         endcase
      end
   endfunction

   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   // all asynchronous inputs pass two flops; only sync2 is read
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         // reset pin bit starts released so standby sees no false wake
         sync1 <= {{(SYNC_W-3){1'b0}}, 3'h4};
         sync2 <= {{(SYNC_W-3){1'b0}}, 3'h4};
         wakeup_pin_prev <= 1'b0;
      end else begin
         sync1 <= {boot1_pin, boot0_pin, external_event_controller_lines,
                   rtc_alarm, low_voltage_detector, usb_wake, enet_wake,
                   i2c_wake, usart_wake, external_reset_pin_n,
                   independent_watchdog_reset, wakeup_pin};
         sync2 <= sync1;
         wakeup_pin_prev <= sync2[0];
      end
   end

   wire s_boot1 = sync2[26];
   wire s_boot0 = sync2[25];
   wire [15:0] s_ext = sync2[24:9];
   wire s_rtc = sync2[8];
   wire s_lvd = sync2[7];
   wire s_usb = sync2[6];
   wire s_enet = sync2[5];
   wire s_i2c = sync2[4];
   wire s_usart = sync2[3];
   wire s_rst_n = sync2[2];
   wire s_wdg = sync2[1];
   wire wakeup_pin_rise = sync2[0] & ~wakeup_pin_prev;

   // the watchdog has its own rc clock; no mode here ever stops it
   assign independent_watchdog_run = 1'b1;

   // ****************************************************************
   // wake source selection
   // ****************************************************************
   // which sources count depends on the mode being left
   always @* begin
      wake_hit = {`LPMS_WC_W{1'b0}};
      if (state == ST_SLEEP || state == ST_DEEP) begin
         wake_hit[`LPMS_WC_EXT] = |s_ext;
         wake_hit[`LPMS_WC_RTC] = s_rtc;
         wake_hit[`LPMS_WC_LVD] = s_lvd;
         wake_hit[`LPMS_WC_USB] = s_usb;
         wake_hit[`LPMS_WC_ENET] = s_enet;
         wake_hit[`LPMS_WC_I2C] = s_i2c;
         wake_hit[`LPMS_WC_USART] = s_usart;
      end
      if (state == ST_SLEEP) begin
         // peripherals still clocked, so any interrupt wakes
         wake_hit[`LPMS_WC_IRQ] = any_irq;
      end
      if (state == ST_STANDBY) begin
         wake_hit[`LPMS_WC_RSTPIN] = ~s_rst_n;
         wake_hit[`LPMS_WC_RTC] = s_rtc;
         wake_hit[`LPMS_WC_WDG] = s_wdg;
         wake_hit[`LPMS_WC_WAKEUP_PIN] = wakeup_pin_rise;
      end
   end

   // ****************************************************************
   // mode sequencing
   // ****************************************************************
   always @* begin
      next_state = state;
      next_mode = mode;
      next_repower_cnt = repower_cnt;
      deep_exit = 1'b0;
      restart_now = 1'b0;
      case (state)
         ST_BOOT: begin
            if (boot_cnt == `LPMS_BOOT_SETTLE) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            // only a request held this cycle is acted on
            if (sleep_req) begin
               next_mode = sleep_mode;
               case (sleep_mode)
                  `LPMS_MODE_SLEEP: next_state = ST_SLEEP;
                  `LPMS_MODE_DEEP: next_state = ST_DEEP;
                  `LPMS_MODE_DEEP1: next_state = ST_DEEP;
                  `LPMS_MODE_DEEP2: next_state = ST_DEEP;
                  `LPMS_MODE_STANDBY: next_state = ST_STANDBY;
                  default: next_mode = mode; // unknown codes ignored
               endcase
            end
         end
         ST_SLEEP: begin
            if (|wake_hit) begin
               next_state = ST_RUN;
            end
         end
         ST_DEEP: begin
            if (|wake_hit) begin
               deep_exit = 1'b1;
               if (mode == `LPMS_MODE_DEEP1) begin
                  next_state = ST_POWERUP;
                  next_repower_cnt = DEEP1_REPOWER[CNT_W-1:0];
               end else if (mode == `LPMS_MODE_DEEP2) begin
                  next_state = ST_POWERUP;
                  next_repower_cnt = DEEP2_REPOWER[CNT_W-1:0];
               end else begin
                  next_state = ST_RUN;
               end
            end
         end
         ST_STANDBY: begin
            // leaving standby restarts the chip and resamples boot
            if (|wake_hit) begin
               next_state = ST_BOOT;
               restart_now = 1'b1;
            end
         end
         ST_POWERUP: begin
            // core clock released only when the count runs out
            if (repower_cnt <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
               next_state = ST_RUN;
               next_repower_cnt = {CNT_W{1'b0}};
            end else begin
               next_repower_cnt = repower_cnt - {{(CNT_W-1){1'b0}}, 1'b1};
            end
         end
         default: next_state = ST_BOOT;
      endcase
   end

   assign ctl = ctl_of(next_state, next_mode);

   // state, counters and registered power controls
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state <= ST_BOOT;
         mode <= `LPMS_MODE_SLEEP;
         repower_cnt <= {CNT_W{1'b0}};
         boot_cnt <= 2'h0;
         {core_clk_en, domain_clk_en, internal_rc_8mhz_en,
          internal_rc_48mhz_en, external_fast_crystal_osc_en, pll_en,
          switchable_core_domain_a_pwr, switchable_core_domain_b_pwr,
          core_regulator_en, sram_upper_retain} <= 10'h3ff;
         chip_restart <= 1'b0;
      end else begin
         state <= next_state;
         mode <= next_mode;
         repower_cnt <= next_repower_cnt;
         {core_clk_en, domain_clk_en, internal_rc_8mhz_en,
          internal_rc_48mhz_en, external_fast_crystal_osc_en, pll_en,
          switchable_core_domain_a_pwr, switchable_core_domain_b_pwr,
          core_regulator_en, sram_upper_retain} <= ctl;
         chip_restart <= restart_now;
         if (next_state == ST_BOOT) begin
            if (state != ST_BOOT) begin
               boot_cnt <= 2'h0;
            end else if (boot_cnt != `LPMS_BOOT_SETTLE) begin
               boot_cnt <= boot_cnt + 2'h1;
            end
         end
      end
   end

   // ****************************************************************
   // boot target latch
   // ****************************************************************
   // pins are caught once the synchroniser has settled, not at reset
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         boot_target <= `LPMS_BOOT_FLASH;
         boot_valid <= 1'b0;
      end else if (state == ST_STANDBY && next_state == ST_BOOT) begin
         boot_valid <= 1'b0;
      end else if (state == ST_BOOT && boot_cnt == `LPMS_BOOT_SETTLE) begin
         boot_valid <= 1'b1;
         if (!s_boot0) begin
            boot_target <= `LPMS_BOOT_FLASH;
         end else if (!s_boot1) begin
            boot_target <= `LPMS_BOOT_SYSMEM;
         end else begin
            boot_target <= `LPMS_BOOT_SRAM;
         end
      end
   end

   // ****************************************************************
   // register port
   // ****************************************************************
   // clock select: deep-sleep exit overrides a write in the same cycle
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sysclk_src <= `LPMS_CTRL_RESET;
      end else if (deep_exit || restart_now) begin
         sysclk_src <= `LPMS_CLK_RC8;
      end else if (reg_write && reg_addr == `LPMS_OFF_CTRL) begin
         sysclk_src <= reg_wdata[1:0];
      end
   end

   // sticky wake causes, write one to clear; a new set beats the clear
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wake_cause <= {`LPMS_WC_W{1'b0}};
      end else if (reg_write && reg_addr == `LPMS_OFF_WAKE_CAUSE) begin
         wake_cause <= (wake_cause & ~reg_wdata[`LPMS_WC_W-1:0]) | wake_hit;
      end else begin
         wake_cause <= wake_cause | wake_hit;
      end
   end

   // read data stands the cycle after the strobe; unmapped reads zero
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_read) begin
         case (reg_addr)
            `LPMS_OFF_CTRL: reg_rdata <= {30'h00000000, sysclk_src};
            `LPMS_OFF_STATUS: reg_rdata <= {21'h000000, mode, 1'b0,
                                            boot_valid, boot_target,
                                            1'b0, state};
            `LPMS_OFF_WAKE_CAUSE: reg_rdata <= {21'h000000, wake_cause};
            default: reg_rdata <= 32'h00000000;
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

endmodule // lpms_sequencer

`default_nettype wire

// [rtl/lpms_defs.vh]
// constants of the low power mode sequencer: register map, field positions,
// mode and clock codes, and the default re-power counts.
// assumes it is included by its bare name from the sequencer source.
`ifndef LPMS_DEFS_VH
`define LPMS_DEFS_VH

// ****************************************************************
// register map (byte offsets on the plain register port)
// ****************************************************************
`define LPMS_ADDR_W 4
`define LPMS_OFF_CTRL 4'h0
`define LPMS_OFF_STATUS 4'h4
`define LPMS_OFF_WAKE_CAUSE 4'h8
`define LPMS_CTRL_RESET 2'h0

// ****************************************************************
// target mode codes carried with the sleep request
// ****************************************************************
`define LPMS_MODE_SLEEP 3'h0
`define LPMS_MODE_DEEP 3'h1
`define LPMS_MODE_DEEP1 3'h2
`define LPMS_MODE_DEEP2 3'h3
`define LPMS_MODE_STANDBY 3'h4

// ****************************************************************
// system clock source codes
// ****************************************************************
`define LPMS_CLK_RC8 2'h0
`define LPMS_CLK_CRYSTAL 2'h1
`define LPMS_CLK_PLL 2'h2
`define LPMS_CLK_RC48 2'h3

// ****************************************************************
// boot target codes
// ****************************************************************
`define LPMS_BOOT_FLASH 2'h0
`define LPMS_BOOT_SYSMEM 2'h1
`define LPMS_BOOT_SRAM 2'h2

// ****************************************************************
// wake cause bit positions
// ****************************************************************
`define LPMS_WC_IRQ 0
`define LPMS_WC_EXT 1
`define LPMS_WC_RTC 2
`define LPMS_WC_LVD 3
`define LPMS_WC_USB 4
`define LPMS_WC_ENET 5
`define LPMS_WC_I2C 6
`define LPMS_WC_USART 7
`define LPMS_WC_RSTPIN 8
`define LPMS_WC_WDG 9
`define LPMS_WC_WAKEUP_PIN 10
`define LPMS_WC_W 11

// ****************************************************************
// timing counts in sys_clk cycles
// ****************************************************************
`define LPMS_BOOT_SETTLE 2'h3
`define LPMS_DEEP1_REPOWER 16
`define LPMS_DEEP2_REPOWER 32

`endif

// [bench/lpms_seq_assertions.sv]
// checker for the sequencer: mode entry, wake, re-power and boot relations
// assumes it is bound to lpms_sequencer and sees only its ports
`timescale 1ns/100ps
`default_nettype none
`include "lpms_defs.vh"
// ********
// checker
// ********
module lpms_seq_checker #(
   parameter DEEP1_REPOWER = 16,
   parameter DEEP2_REPOWER = 32
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic sleep_req,
   input wire logic [2:0] sleep_mode,
   input wire logic boot0_pin,
   input wire logic boot1_pin,
   input wire logic core_clk_en,
   input wire logic domain_clk_en,
   input wire logic internal_rc_8mhz_en,
   input wire logic internal_rc_48mhz_en,
   input wire logic external_fast_crystal_osc_en,
   input wire logic pll_en,
   input wire logic switchable_core_domain_a_pwr,
   input wire logic switchable_core_domain_b_pwr,
   input wire logic core_regulator_en,
   input wire logic sram_upper_retain,
   input wire logic independent_watchdog_run,
   input wire logic [1:0] sysclk_src,
   input wire logic [1:0] boot_target,
   input wire logic boot_valid
);
   logic [7:0] rep_cnt;
   logic was_d2;
   wire logic run_ok = core_clk_en && boot_valid;
   wire logic osc_off = !internal_rc_8mhz_en && !internal_rc_48mhz_en &&
      !external_fast_crystal_osc_en && !pll_en;
   // re-power cycles; sleep is told apart because its pll stays on
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rep_cnt <= 8'h00;
         was_d2 <= 1'b0;
      end else begin
         rep_cnt <= (!core_clk_en && domain_clk_en && !pll_en) ?
            rep_cnt + 8'h01 : 8'h00;
         was_d2 <= !core_clk_en && (was_d2 || !switchable_core_domain_a_pwr);
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   sequence s_req(logic [2:0] m);
      run_ok && sleep_req && sleep_mode == m;
   endsequence
   sequence s_repowered;
      $rose(core_clk_en) && rep_cnt != 8'h00;
   endsequence
   property p_boot;
      $rose(boot_valid) |-> boot_target == (!boot0_pin ? `LPMS_BOOT_FLASH :
         boot1_pin ? `LPMS_BOOT_SRAM : `LPMS_BOOT_SYSMEM);
   endproperty
   a_boot: assert property (p_boot) else $error("boot target");
   property p_sleep;
      s_req(`LPMS_MODE_SLEEP) |=> !core_clk_en && domain_clk_en && pll_en;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep gating");
   property p_deep;
      run_ok && sleep_req && sleep_mode inside {[3'h1:3'h3]} |=>
         !core_clk_en && !domain_clk_en && osc_off;
   endproperty
   a_deep: assert property (p_deep) else $error("deep gating");
   property p_keep;
      s_req(`LPMS_MODE_DEEP) |=> switchable_core_domain_a_pwr &&
         switchable_core_domain_b_pwr && sram_upper_retain;
   endproperty
   a_keep: assert property (p_keep) else $error("deep retention");
   property p_d1;
      s_req(`LPMS_MODE_DEEP1) |=> switchable_core_domain_a_pwr &&
         !switchable_core_domain_b_pwr;
   endproperty
   a_d1: assert property (p_d1) else $error("deep1 power");
   property p_d2;
      s_req(`LPMS_MODE_DEEP2) |=> !switchable_core_domain_a_pwr &&
         !switchable_core_domain_b_pwr && !sram_upper_retain;
   endproperty
   a_d2: assert property (p_d2) else $error("deep2 power");
   property p_stby;
      s_req(`LPMS_MODE_STANDBY) |=> !core_regulator_en && osc_off &&
         !domain_clk_en;
   endproperty
   a_stby: assert property (p_stby) else $error("standby power");
   property p_rc8;
      $rose(domain_clk_en) && $past(core_regulator_en) |->
         sysclk_src == `LPMS_CLK_RC8 && internal_rc_8mhz_en;
   endproperty
   a_rc8: assert property (p_rc8) else $error("exit clock");
   property p_repower;
      s_repowered |-> rep_cnt == (was_d2 ? DEEP2_REPOWER : DEEP1_REPOWER);
   endproperty
   a_repower: assert property (p_repower)
      else $error("delay");
   property p_wdg;
      independent_watchdog_run;
   endproperty
   a_wdg: assert property (p_wdg) else $error("watchdog stopped");
endmodule // lpms_seq_checker
bind lpms_sequencer lpms_seq_checker #(.DEEP1_REPOWER(DEEP1_REPOWER),
   .DEEP2_REPOWER(DEEP2_REPOWER)) u_chk (.*);
`default_nettype wire

// [bench/lpms_cpu_model.sv]
// cpu side model: raises a held sleep request with a mode code on command
// assumes the sequencer's sys_clk and a one-cycle pulse on go
`timescale 1ns/100ps
`default_nettype none
module lpms_cpu_model (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic go,
   input wire logic [2:0] mode_in,
   input wire logic core_clk_en,
   output logic sleep_req,
   output logic [2:0] sleep_mode
);
   logic [2:0] hold;
   // held until the core clock stops; a refused code is dropped after five
   // cycles, and the idle mode lines show the inverse of their last value
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sleep_req <= 1'b0;
         sleep_mode <= 3'h0;
         hold <= 3'h0;
      end else if (go) begin
         sleep_req <= 1'b1;
         sleep_mode <= mode_in;
         hold <= 3'h0;
      end else if (sleep_req) begin
         hold <= hold + 3'h1;
         if (!core_clk_en || hold == 3'h4) begin
            sleep_req <= 1'b0;
            sleep_mode <= ~sleep_mode;
         end
      end
   end
endmodule // lpms_cpu_model
`default_nettype wire

// [bench/low_power_mode_sequencer_bench.sv]
// self-checking bench: boot straps, every mode, every wake source
// assumes lpms_sequencer, the cpu model and the bound checker
`timescale 1ns/100ps
`default_nettype none
`include "lpms_defs.vh"
module low_power_mode_sequencer_bench;
   logic sys_clk = 1'b0, reset = 1'b1, go = 1'b0;
   logic reg_write = 1'b0, reg_read = 1'b0, boot0_pin = 1'b0;
   logic boot1_pin = 1'b0, sleep_req, boot_valid, chip_restart, wdg_run;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic [2:0] mode_in = 3'h0, sleep_mode;
   logic [10:0] src = 11'h000; // 0 irq, 1-6 deep, 7-9 standby, 10 lines
   logic [15:0] lmask = 16'h0001;
   logic [1:0] sysclk_src, boot_target;
   wire logic [9:0] pw;
   int checks = 0, miscompares = 0, restarts = 0;
   int stby[4] = '{9, 1, 7, 8};
   initial forever #10 sys_clk = ~sys_clk;
   lpms_cpu_model cpu (.sys_clk(sys_clk), .reset(reset), .go(go),
      .mode_in(mode_in), .core_clk_en(pw[9]), .sleep_req(sleep_req),
      .sleep_mode(sleep_mode));
   lpms_sequencer dut (.sys_clk(sys_clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .sleep_req(sleep_req),
      .sleep_mode(sleep_mode), .any_irq(src[0]), .boot0_pin(boot0_pin),
      .boot1_pin(boot1_pin),
      .external_event_controller_lines(src[10] ? lmask : 16'h0000),
      .rtc_alarm(src[1]), .low_voltage_detector(src[2]), .usb_wake(src[3]),
      .enet_wake(src[4]), .i2c_wake(src[5]), .usart_wake(src[6]),
      .external_reset_pin_n(!src[9]), .independent_watchdog_reset(src[7]),
      .wakeup_pin(src[8]), .core_clk_en(pw[9]), .domain_clk_en(pw[8]),
      .internal_rc_8mhz_en(pw[7]), .internal_rc_48mhz_en(pw[6]),
      .external_fast_crystal_osc_en(pw[5]), .pll_en(pw[4]),
      .switchable_core_domain_a_pwr(pw[3]),
      .switchable_core_domain_b_pwr(pw[2]), .core_regulator_en(pw[1]),
      .sram_upper_retain(pw[0]), .independent_watchdog_run(wdg_run),
      .sysclk_src(sysclk_src), .boot_target(boot_target),
      .boot_valid(boot_valid), .chip_restart(chip_restart));
   always @(posedge sys_clk) if (chip_restart === 1'b1) restarts++;
   task automatic chk(input string w, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", w, e, g);
      end
   endtask
   // masked expectation {mask, value}; unstated outputs are left unchecked
   function automatic logic [19:0] exp_pw(input logic [2:0] m);
      case (m)
         `LPMS_MODE_SLEEP: exp_pw = {10'h3ff, 10'h1ff};
         `LPMS_MODE_DEEP: exp_pw = {10'h3ff, 10'h00f};
         `LPMS_MODE_DEEP1: exp_pw = {10'h3fe, 10'h00a};
         `LPMS_MODE_DEEP2: exp_pw = {10'h3ff, 10'h002};
         `LPMS_MODE_STANDBY: exp_pw = {10'h3f2, 10'h000};
         default: exp_pw = {10'h3ff, 10'h3ff};
      endcase
   endfunction
   function automatic logic [1:0] exp_boot(input logic b0, b1);
      exp_boot = !b0 ? `LPMS_BOOT_FLASH :
         b1 ? `LPMS_BOOT_SRAM : `LPMS_BOOT_SYSMEM;
   endfunction
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] m, e, string w);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 chk(w, e, reg_rdata & m);
   endtask
   task automatic do_reset(input logic b0, b1);
      @(posedge sys_clk);
      reset <= 1'b1;
      boot0_pin <= b0;
      boot1_pin <= b1;
      repeat (16) @(posedge sys_clk);
      reset <= 1'b0;
   endtask
   // bounded wait for the core clock with the boot done
   task automatic wait_run(input string w);
      int n;
      n = 0;
      while (!(pw[9] === 1'b1 && boot_valid === 1'b1) && n < 300) begin
         @(posedge sys_clk);
         #1 n++;
      end
      chk(w, 1, n < 300);
   endtask
   // enter mode m, check outputs, then wake it with source s
   task automatic do_mode(input logic [2:0] m, input int s);
      logic [19:0] e;
      logic [1:0] ck;
      int r;
      ck = 2'($urandom_range(3, 1));
      e = exp_pw(m);
      r = restarts;
      lmask <= 16'h0001 << $urandom_range(15);
      wr(`LPMS_OFF_CTRL, {30'h0, ck});
      @(posedge sys_clk);
      go <= 1'b1;
      mode_in <= m;
      @(posedge sys_clk);
      go <= 1'b0;
      @(posedge sys_clk);
      #1 chk("mode", e[9:0], pw & e[19:10]);
      // inputs move only on a rising edge, never just after it
      @(posedge sys_clk);
      if (m == `LPMS_MODE_STANDBY) begin
         src[10] <= 1'b1;
         repeat (6) @(posedge sys_clk);
         #1 chk("standby on event", r, restarts);
         chk("watchdog", 1, wdg_run);
         @(posedge sys_clk);
         src[10] <= 1'b0;
         repeat (3) @(posedge sys_clk);
      end
      if (m > `LPMS_MODE_STANDBY) begin
         repeat (6) @(posedge sys_clk);
         #1 chk("refused", 32'h3ff, pw);
      end else begin
         src[s] <= 1'b1;
         wait_run("wake");
         chk("after wake", 32'h3ff, pw);
         @(posedge sys_clk);
         src <= 11'h000;
         if (m == `LPMS_MODE_STANDBY) begin
            repeat (8) @(posedge sys_clk);
            chk("restart", r + 1, restarts);
         end else begin
            ck = (m == `LPMS_MODE_SLEEP) ? ck : `LPMS_CLK_RC8;
            rd(`LPMS_OFF_CTRL, 32'h3, ck, "clock");
            if (m == `LPMS_MODE_SLEEP)
               rd(`LPMS_OFF_WAKE_CAUSE, 32'h1, 32'h1, "irq cause");
         end
      end
   endtask
   task end_of_test;
      $display("checks %0d, miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // about 500 cycles expected; twenty-four times that means a hang
   initial begin
      repeat (12000) @(posedge sys_clk);
      miscompares++;
      end_of_test;
   end
   initial begin
      void'($urandom(27));
      for (int b = 0; b < 3; b++) begin
         do_reset(b != 0, b == 2 || (b == 0 && $urandom_range(1) == 1));
         wait_run("boot");
         chk("boot", exp_boot(boot0_pin, boot1_pin), boot_target);
      end
      rd(`LPMS_OFF_CTRL, 32'h3, `LPMS_CTRL_RESET, "ctrl");
      wr(`LPMS_OFF_STATUS, 32'hffffffff);
      wr(4'hc, 32'hffffffff);
      rd(`LPMS_OFF_STATUS, 32'h77, 32'h61, "status");
      rd(4'hc, 32'hffffffff, 32'h0, "unmapped");
      rd(`LPMS_OFF_WAKE_CAUSE, 32'hffffffff, 32'h0, "wake cause");
      do_mode(`LPMS_MODE_SLEEP, 0);
      for (int i = 0; i < 7; i++)
         do_mode(3'(1 + i % 3), i == 0 ? 10 : i);
      for (int m = 5; m < 8; m++)
         do_mode(3'(m), 0);
      foreach (stby[k])
         do_mode(`LPMS_MODE_STANDBY, stby[k]);
      end_of_test;
   end
endmodule // low_power_mode_sequencer_bench
`default_nettype wire
